//--- include/ppte_pkg.sv
/*
 * package for the symbol-pair port and transmitter-enable block:
 * register map, field positions, reset values, line timing.
 * assumes a 100 MHz system clock and an AXI4-Lite register bus.
 */
package ppte_pkg;
    // printed register indices; byte address is four times the index
    localparam logic [5:0] PPTE_IDX_RSVD_A = 6'h3e;
    localparam logic [5:0] PPTE_IDX_RSVD_B = 6'h3f;
    // registers of this block, by byte address
    localparam logic [7:0] PPTE_ADDR_MODE = 8'h00;
    localparam logic [7:0] PPTE_ADDR_XSTATE = 8'h04;
    localparam logic [7:0] PPTE_ADDR_STATUS = 8'h08;
    localparam logic [7:0] PPTE_ADDR_RSVD_A = {PPTE_IDX_RSVD_A, 2'b00};
    localparam logic [7:0] PPTE_ADDR_RSVD_B = {PPTE_IDX_RSVD_B, 2'b00};
    // mode register fields
    localparam int PPTE_MODE_XEN_BIT = 0;
    localparam logic PPTE_MODE_XEN_RST = 1'b0;
    // transmit state field
    localparam int PPTE_XSTATE_W = 3;
    localparam logic [2:0] PPTE_XSTATE_OFF = 3'h0;
    localparam logic [2:0] PPTE_XSTATE_RST = 3'h0;
    // status fields
    localparam int PPTE_STAT_SIG_BIT = 0;
    localparam int PPTE_STAT_REQPERR_BIT = 1;
    localparam int PPTE_STAT_TXEN_BIT = 2;
    localparam logic [31:0] PPTE_RSVD_READ = 32'h0000_0000;
    // axi responses
    localparam logic [1:0] PPTE_RESP_OKAY = 2'b00;
    localparam logic [1:0] PPTE_RESP_SLVERR = 2'b10;
    // timing: system clock and serial line rate
    localparam int PPTE_CLK_MHZ = 100;
    localparam int PPTE_LINE_MBPS = 125;
    localparam int PPTE_SYM_BITS = 10;
    // byte clock 12.5 MHz: one 10-bit coded pair per byte clock at the line rate
    localparam int PPTE_BYTE_DIV = (PPTE_CLK_MHZ * PPTE_SYM_BITS) / PPTE_LINE_MBPS;
endpackage

//--- logic/ppte_shift.sv
/*
 * serialiser/deserialiser for one 10-bit coded pair worth of line bits.
 * assumes bit_en pulses at the line bit rate; loads on load_en.
 */
`timescale 1ns/1ps
`default_nettype none
module ppte_shift #(
    parameter int W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic bit_en,
    input wire logic load_en,
    input wire logic [W-1:0] load_data,
    input wire logic ser_in,
    output logic ser_out,
    output logic [W-1:0] par_out
);
    logic [W-1:0] tx_sh_ff;
    logic [W-1:0] rx_sh_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_sh_ff <= '0;
        end else if (load_en) begin
            tx_sh_ff <= load_data;
        end else if (bit_en) begin
            tx_sh_ff <= {tx_sh_ff[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sh_ff <= '0;
        end else if (bit_en) begin
            rx_sh_ff <= {rx_sh_ff[W-2:0], ser_in};
        end
    end

    assign ser_out = tx_sh_ff[W-1];
    assign par_out = rx_sh_ff;
endmodule
`default_nettype wire

//--- logic/ppte_top.sv
/*
 * symbol-pair port and medium transmitter-enable logic with an AXI4-Lite
 * register slave. assumes all pins synchronous to clk; the upstream party
 * keeps odd parity and pair layout on the request path.
 */
`timescale 1ns/1ps
`default_nettype none
module ppte_top import ppte_pkg::*; #(
    parameter int BYTE_DIV = PPTE_BYTE_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_enable_polarity_pin,
    output logic medium_tx_enable_out,
    input wire logic line_serial_in,
    output logic line_serial_out,
    input wire logic line_signal_present,
    input wire logic [3:0] ind_first_sym,
    input wire logic [3:0] ind_second_sym,
    input wire logic ind_is_ctrl,
    output logic indicate_parity,
    output logic indicate_ctrl_flag,
    output logic [7:0] indicate_symbols,
    input wire logic request_parity,
    input wire logic request_ctrl_flag,
    input wire logic [7:0] request_symbols,
    output logic byte_en,
    output logic [7:0] req_pair,
    output logic req_is_ctrl,
    output logic req_parity_err
);
    logic xmit_enable_mode_bit_ff;
    logic [2:0] transmit_state_field_ff;
    logic [3:0] div_ff;
    logic byte_en_ff;
    logic tx_en_ff, sig_ff, req_perr_ff, ser_ff;
    logic bit_en, ser_raw;
    logic [PPTE_SYM_BITS-1:0] rx_par;
    logic [7:0] req_pair_ff;
    logic req_ctrl_ff, ip_ff, ic_ff;
    logic [7:0] is_ff;
    logic aw_ff, w_ff, bv_ff, rv_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;
    logic do_wr;

    // byte clock enable from the divider; line bit enable tied high, one bit per clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= '0;
            byte_en_ff <= 1'b0;
        end else begin
            div_ff <= (div_ff == 4'(BYTE_DIV - 1)) ? 4'h0 : div_ff + 4'h1;
            byte_en_ff <= (div_ff == 4'(BYTE_DIV - 1));
        end
    end
    assign bit_en = 1'b1;

    ppte_shift #(.W(PPTE_SYM_BITS)) u_shift (
        .clk(clk),
        .rst(rst),
        .bit_en(bit_en),
        .load_en(byte_en_ff),
        .load_data({ip_ff, ic_ff, is_ff}),
        .ser_in(line_serial_in),
        .ser_out(ser_raw),
        .par_out(rx_par)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_ff <= 1'b0;
        end else begin
            ser_ff <= ser_raw;
        end
    end

    // indicate path: one pair per byte clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ip_ff <= 1'b1;
            ic_ff <= 1'b0;
            is_ff <= 8'h00;
        end else if (byte_en_ff) begin
            is_ff <= {ind_first_sym, ind_second_sym};
            ic_ff <= ind_is_ctrl;
            ip_ff <= ~(^{ind_is_ctrl, ind_first_sym, ind_second_sym});
        end
    end

    // request path capture and parity check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_pair_ff <= 8'h00;
            req_ctrl_ff <= 1'b0;
            req_perr_ff <= 1'b0;
        end else if (byte_en_ff) begin
            req_pair_ff <= request_symbols;
            req_ctrl_ff <= request_ctrl_flag;
            req_perr_ff <= ~(^{request_parity, request_ctrl_flag, request_symbols});
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sig_ff <= 1'b0;
        end else begin
            sig_ff <= line_signal_present;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_ff <= 1'b1;
        end else if (xmit_enable_mode_bit_ff &&
                     transmit_state_field_ff != PPTE_XSTATE_OFF) begin
            tx_en_ff <= tx_enable_polarity_pin;
        end else begin
            tx_en_ff <= ~tx_enable_polarity_pin;
        end
    end

    // axi write channel: address and data taken in either order
    assign do_wr = aw_ff && w_ff && !bv_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bv_ff <= 1'b0;
            bresp_ff <= PPTE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                bv_ff <= 1'b1;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                unique case (awaddr_ff)
                    PPTE_ADDR_MODE, PPTE_ADDR_XSTATE: bresp_ff <= PPTE_RESP_OKAY;
                    default: bresp_ff <= PPTE_RESP_SLVERR;
                endcase
            end else if (bv_ff && s_axi_bready) begin
                bv_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xmit_enable_mode_bit_ff <= PPTE_MODE_XEN_RST;
            transmit_state_field_ff <= PPTE_XSTATE_RST;
        end else if (do_wr && wstrb_ff[0]) begin
            if (awaddr_ff == PPTE_ADDR_MODE) begin
                xmit_enable_mode_bit_ff <= wdata_ff[PPTE_MODE_XEN_BIT];
            end
            if (awaddr_ff == PPTE_ADDR_XSTATE) begin
                transmit_state_field_ff <= wdata_ff[PPTE_XSTATE_W-1:0];
            end
        end
    end

    always_comb begin
        nxt_rdata = '0;
        nxt_rresp = PPTE_RESP_OKAY;
        unique case (s_axi_araddr)
            PPTE_ADDR_MODE: nxt_rdata[PPTE_MODE_XEN_BIT] = xmit_enable_mode_bit_ff;
            PPTE_ADDR_XSTATE: nxt_rdata[PPTE_XSTATE_W-1:0] = transmit_state_field_ff;
            PPTE_ADDR_STATUS: begin
                nxt_rdata[PPTE_STAT_SIG_BIT] = sig_ff;
                nxt_rdata[PPTE_STAT_REQPERR_BIT] = req_perr_ff;
                nxt_rdata[PPTE_STAT_TXEN_BIT] = tx_en_ff;
            end
            PPTE_ADDR_RSVD_A, PPTE_ADDR_RSVD_B: nxt_rdata = PPTE_RSVD_READ;
            default: nxt_rresp = PPTE_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rv_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= PPTE_RESP_OKAY;
        end else if (s_axi_arvalid && !rv_ff) begin
            rv_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end else if (rv_ff && s_axi_rready) begin
            rv_ff <= 1'b0;
        end
    end

    // ready is the registered "slot free" state
    assign s_axi_awready = !aw_ff;
    assign s_axi_wready = !w_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rv_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign medium_tx_enable_out = tx_en_ff;
    assign line_serial_out = ser_ff;
    assign indicate_parity = ip_ff;
    assign indicate_ctrl_flag = ic_ff;
    assign indicate_symbols = is_ff;
    assign byte_en = byte_en_ff;
    assign req_pair = req_pair_ff;
    assign req_is_ctrl = req_ctrl_ff;
    assign req_parity_err = req_perr_ff;

    AST_TXEN_OFF: assert property (@(posedge clk) disable iff (rst)
        (!xmit_enable_mode_bit_ff || transmit_state_field_ff == PPTE_XSTATE_OFF)
        |=> medium_tx_enable_out == ~$past(tx_enable_polarity_pin))
        else $error("tx enable not inverted while off");
    AST_TXEN_ON: assert property (@(posedge clk) disable iff (rst)
        (xmit_enable_mode_bit_ff && transmit_state_field_ff != PPTE_XSTATE_OFF)
        |=> medium_tx_enable_out == $past(tx_enable_polarity_pin))
        else $error("tx enable not following polarity");
    AST_IND_PARITY: assert property (@(posedge clk) disable iff (rst)
        ^{indicate_parity, indicate_ctrl_flag, indicate_symbols} == 1'b1)
        else $error("indicate parity not odd");
    AST_IND_CTRL: assert property (@(posedge clk) disable iff (rst)
        byte_en_ff |=> indicate_ctrl_flag == $past(ind_is_ctrl))
        else $error("indicate flag wrong");
    AST_IND_ORDER: assert property (@(posedge clk) disable iff (rst)
        byte_en_ff |=> indicate_symbols[7:4] == $past(ind_first_sym)
        && indicate_symbols[3:0] == $past(ind_second_sym))
        else $error("indicate nibble order wrong");
    AST_REQ_PERR: assert property (@(posedge clk) disable iff (rst)
        byte_en_ff |=> req_parity_err ==
        ~(^$past({request_parity, request_ctrl_flag, request_symbols})))
        else $error("request parity check wrong");
    AST_REQ_HOLD: assert property (@(posedge clk) disable iff (rst)
        !byte_en_ff |=> $stable(req_pair) && $stable(req_is_ctrl))
        else $error("request pair changed between byte clocks");
    AST_BYTE_RATE: assert property (@(posedge clk) disable iff (rst)
        byte_en_ff |=> !byte_en_ff [*7] ##1 byte_en_ff)
        else $error("byte enable spacing wrong");
    AST_RSVD_WR: assert property (@(posedge clk) disable iff (rst)
        do_wr && awaddr_ff != PPTE_ADDR_MODE && awaddr_ff != PPTE_ADDR_XSTATE
        |=> s_axi_bvalid && s_axi_bresp == PPTE_RESP_SLVERR)
        else $error("unmapped write not refused");
    AST_SIG: assert property (@(posedge clk) disable iff (rst)
        ##1 sig_ff == $past(line_signal_present))
        else $error("signal detect not tracked");
    COV_TX_ON: cover property (@(posedge clk) disable iff (rst)
        $rose(xmit_enable_mode_bit_ff));
    COV_CTRL_PAIR: cover property (@(posedge clk) disable iff (rst)
        byte_en_ff && ind_is_ctrl);
    COV_REQ_ERR: cover property (@(posedge clk) disable iff (rst) $rose(req_parity_err));
    COV_RD: cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

//--- tb/phy_port_and_tx_enable_tb.sv
/*
 * self-checking bench for the symbol-pair port and tx enable block.
 * assumes ppte_pkg, ppte_top and the upstream model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module phy_port_and_tx_enable_tb;
    import ppte_pkg::*;
    logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, indicate_symbols, req_pair, request_symbols;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb, ind_first_sym, ind_second_sym, up_first, up_second;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, byte_en;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_enable_polarity_pin, medium_tx_enable_out, line_serial_in, line_signal_present;
    logic ind_is_ctrl, indicate_parity, indicate_ctrl_flag, request_parity, request_ctrl_flag;
    logic req_is_ctrl, req_parity_err, up_ctrl, up_bad, line_serial_out;
    logic [9:0] lw;
    logic [3:0] pf, ps, qf, qs;
    logic pc, qc, qb;
    int num_errors = 0;
    int n_checks = 0;
    ppte_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tx_enable_polarity_pin(tx_enable_polarity_pin),
        .medium_tx_enable_out(medium_tx_enable_out), .line_serial_in(line_serial_in),
        .line_serial_out(line_serial_out), .line_signal_present(line_signal_present),
        .ind_first_sym(ind_first_sym), .ind_second_sym(ind_second_sym),
        .ind_is_ctrl(ind_is_ctrl), .indicate_parity(indicate_parity),
        .indicate_ctrl_flag(indicate_ctrl_flag), .indicate_symbols(indicate_symbols),
        .request_parity(request_parity), .request_ctrl_flag(request_ctrl_flag),
        .request_symbols(request_symbols), .byte_en(byte_en), .req_pair(req_pair),
        .req_is_ctrl(req_is_ctrl), .req_parity_err(req_parity_err));
    ppte_upstream up_u (.clk(clk), .rst(rst), .first_sym(up_first), .second_sym(up_second),
        .is_ctrl(up_ctrl), .bad_par(up_bad), .request_parity(request_parity),
        .request_ctrl_flag(request_ctrl_flag), .request_symbols(request_symbols));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic exp_par(input logic c, input logic [7:0] s);
        return ~(^{c, s});
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            $display("MISMATCH t=%0t wait ran out", $time);
            final_report;
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        logic ta, tw, bv;
        logic [1:0] br;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            bv = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (bv === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        tmo(k, 64);
        chk(32'(br), 32'(er), "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int k;
        logic ta, rv;
        logic [1:0] rr;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge clk);
            ta = s_axi_arvalid & s_axi_arready;
            rv = s_axi_rvalid;
            rr = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (rv === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        tmo(k, 64);
        chk(32'(rr), 32'(er), "read response");
    endtask
    // one pair per byte clock on both paths, checked against the previous pair
    task automatic pair_step(input bit do_chk);
        int k;
        int j;
        for (k = 0; k < 20; k++) begin
            @(negedge clk);
            if (byte_en === 1'b1) break;
        end
        tmo(k, 20);
        @(posedge clk);
        seed = lfsr(seed);
        ind_first_sym <= seed[3:0];
        ind_second_sym <= seed[7:4];
        ind_is_ctrl <= seed[8];
        up_first <= seed[12:9];
        up_second <= seed[16:13];
        up_ctrl <= seed[17];
        up_bad <= (seed[20:18] == 3'h0);
        line_serial_in <= seed[21];
        @(negedge clk);
        if (do_chk) begin
            chk(32'(indicate_symbols), 32'({pf, ps}), "indicate symbols");
            chk(32'(indicate_ctrl_flag), 32'(pc), "indicate flag");
            chk(32'(indicate_parity), 32'(exp_par(pc, {pf, ps})), "indicate parity");
            chk(32'({req_is_ctrl, req_pair}), 32'({qc, qf, qs}), "request pair");
            chk(32'(req_parity_err), 32'(qb), "request parity error");
            // shifter reloads with the pair before the previous one, msb first, one bit per clk
            for (j = 0; j < 6; j++) begin
                @(negedge clk);
                chk(32'(line_serial_out), 32'(lw[9-j]), "serial out");
            end
            lw = {exp_par(pc, {pf, ps}), pc, pf, ps};
        end
        {pc, ps, pf} = seed[8:0];
        {qb, qc, qs, qf} = {(seed[20:18] == 3'h0), seed[17:9]};
    endtask
    initial begin
        int i;
        logic xen, pin, exp_en;
        logic [2:0] st;
        logic [31:0] d;
        rst = 1'b1;
        seed = 32'h0001_30f6;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        {tx_enable_polarity_pin, line_serial_in, line_signal_present} = '0;
        {ind_first_sym, ind_second_sym, ind_is_ctrl, up_first, up_second, up_ctrl} = '0;
        up_bad = 1'b0;
        lw = {exp_par(1'b0, 8'h00), 9'h000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            xen = i[2];
            st = i[1] ? ((seed[2:0] == 3'h0) ? 3'h7 : seed[2:0]) : PPTE_XSTATE_OFF;
            pin = i[0];
            axi_wr(PPTE_ADDR_MODE, 32'(xen), PPTE_RESP_OKAY);
            axi_wr(PPTE_ADDR_XSTATE, 32'(st), PPTE_RESP_OKAY);
            @(posedge clk);
            tx_enable_polarity_pin <= pin;
            repeat (2) @(posedge clk);
            @(negedge clk);
            exp_en = (xen && st != PPTE_XSTATE_OFF) ? pin : !pin;
            chk(32'(medium_tx_enable_out), 32'(exp_en), "tx en");
        end
        $display("test tx_enable done");
        axi_rd(PPTE_ADDR_RSVD_A, PPTE_RESP_OKAY, d);
        chk(d, PPTE_RSVD_READ, "reserved read");
        axi_wr(8'h40, 32'h0000_0000, PPTE_RESP_SLVERR);
        axi_rd(PPTE_ADDR_RSVD_B, PPTE_RESP_OKAY, d);
        chk(d, PPTE_RSVD_READ, "reserved after write");
        axi_rd(PPTE_ADDR_MODE, PPTE_RESP_OKAY, d);
        chk(32'(d[PPTE_MODE_XEN_BIT]), 32'h1, "mode kept");
        axi_rd(8'h40, PPTE_RESP_SLVERR, d);
        $display("test reserved done");
        for (i = 1; i >= 0; i--) begin
            @(posedge clk);
            line_signal_present <= i[0];
            repeat (3) @(posedge clk);
            axi_rd(PPTE_ADDR_STATUS, PPTE_RESP_OKAY, d);
            chk(32'(d[PPTE_STAT_SIG_BIT]), 32'(i[0]), "signal present");
            chk(32'(d[PPTE_STAT_TXEN_BIT]), 32'(exp_en), "status tx en");
        end
        $display("test signal detect done");
        pair_step(1'b0);
        repeat (60) pair_step(1'b1);
        $display("test pairs done");
        final_report;
    end
    initial begin
        repeat (50000) @(posedge clk);
        tmo(1, 0);
    end
endmodule
`default_nettype wire

//--- tb/ppte_upstream.sv
/*
 * upstream party model: drives the request path of the symbol-pair port.
 * assumes the bench supplies the symbols; loads them one clk later.
 */
`timescale 1ns/1ps
`default_nettype none
module ppte_upstream (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] first_sym,
    input wire logic [3:0] second_sym,
    input wire logic is_ctrl,
    input wire logic bad_par,
    output logic request_parity,
    output logic request_ctrl_flag,
    output logic [7:0] request_symbols
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            request_symbols <= 8'h00;
            request_ctrl_flag <= 1'b0;
            request_parity <= 1'b1;
        end else begin
            request_symbols <= {first_sym, second_sym};
            request_ctrl_flag <= is_ctrl;
            // bad_par breaks odd parity on purpose
            request_parity <= ~(^{is_ctrl, first_sym, second_sym}) ^ bad_par;
        end
    end
endmodule
`default_nettype wire
